// [src/aim_pkg.sv]
/*
 * shared constants and carrier types for the audio transceiver interrupt
 * gating block: register offsets, reset values, trigger codes, bus response codes.
 * assumes a 32-bit axi4-lite register bus with byte addressing.
 */
package aim_pkg;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [3:0] IDX_G1_STATUS   = 4'h7;
   localparam logic [3:0] IDX_G2_STATUS   = 4'h8;
   localparam logic [3:0] IDX_G1_ENABLE   = 4'h9;
   localparam logic [3:0] IDX_G1_TRIG_MSB = 4'ha;
   localparam logic [3:0] IDX_G1_TRIG_LSB = 4'hb;
   localparam logic [3:0] IDX_G2_ENABLE   = 4'hc;
   localparam logic [3:0] IDX_G2_TRIG_MSB = 4'hd;
   localparam logic [3:0] IDX_G2_TRIG_LSB = 4'he;
   localparam int         ADDR_W          = 6;

   localparam logic [7:0] RST_REG8     = 8'h00;
   localparam logic [7:0] G2_VALID     = 8'h3f;
   localparam int         G1_SRC       = 8;
   localparam int         G2_SRC       = 6;

   localparam logic [1:0] TRIG_RISE    = 2'h0;
   localparam logic [1:0] TRIG_FALL    = 2'h1;
   localparam logic [1:0] TRIG_LEVEL   = 2'h2;

   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef struct packed {
      logic        time_slip_event;
      logic        output_slip_event;
      logic        converter_error_event;
      logic        left_overrange_event;
      logic        right_overrange_event;
      logic        cs_d_to_e_transfer_event;
      logic        cs_e_to_f_transfer_event;
      logic        receiver_fault_event;
   } aim_g1_src_t;

   typedef struct packed {
      logic        varispeed_overflow_event;
      logic        converter_unlock_event;
      logic        ub_d_to_e_transfer_event;
      logic        ub_e_to_f_transfer_event;
      logic        subcode_ready_event;
      logic        user_fifo_overwrite_event;
   } aim_g2_src_t;

   typedef struct packed {
      logic [7:0]  enable;
      logic [7:0]  trig_msb;
      logic [7:0]  trig_lsb;
   } aim_grp_cfg_t;
endpackage

// [src/aim_trigger.sv]
/*
 * per-source trigger detector for one event group: rising, falling or level
 * qualification, gated by the enable mask, with sticky status and read clear.
 * assumes source conditions are synchronous to aclk.
 */
`timescale 1ns/1ps
module aim_trigger #(
   parameter int N = 8
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // source conditions and configuration
   input  wire logic [N-1:0] cond,
   input  wire logic [N-1:0] enable,
   input  wire logic [N-1:0] trig_msb,
   input  wire logic [N-1:0] trig_lsb,
   // status read side effect
   input  wire logic         rd_clear,
   output      logic [N-1:0] status
);
   typedef struct packed {
      logic [N-1:0] prev;
      logic [N-1:0] sticky;
   } aim_trg_st_t;

   aim_trg_st_t st_r;
   aim_trg_st_t st_nxt;
   logic [N-1:0] hit;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         always_comb begin
            unique case ({trig_msb[g], trig_lsb[g]})
               aim_pkg::TRIG_RISE:  hit[g] = cond[g] & ~st_r.prev[g]; // [RL5] [RL6] [RL7]
               aim_pkg::TRIG_FALL:  hit[g] = ~cond[g] & st_r.prev[g]; // [RL7]
               aim_pkg::TRIG_LEVEL: hit[g] = cond[g];                 // [RL7]
               default:             hit[g] = 1'b0;  // reserved code never flags
            endcase
         end
      end
   endgenerate

   always_comb begin
      st_nxt      = st_r;
      st_nxt.prev = cond;
      // a new hit in the read cycle survives the clear; level sources stay set while their condition holds
      st_nxt.sticky = ((rd_clear ? '0 : st_r.sticky) | hit) & enable; // [RL1] [RL3] [RL9] [RL10]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // masked on the way out so a bit reads zero from the very cycle its mask drops
   assign status = st_r.sticky & enable; // [RL9]

   AST_MASKED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(enable[0]) |=> !status[0]) else $error("masked status bit set"); // [RL9]
   AST_LEVEL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      (enable[0] && trig_msb[0] && !trig_lsb[0] && cond[0] ##1 enable[0]) |-> status[0])
      else $error("level source not flagged"); // [RL10]
endmodule

// [src/aim_axil_slave.sv]
/*
 * axi4-lite slave front end: accepts one write and one read at a time and
 * hands them to the register file as single-cycle strobes; a write strobes only when wstrb[0] is set.
 * assumes a well-behaved master holding valid and payload until ready.
 */
`timescale 1ns/1ps
module aim_axil_slave #(
   parameter int AW = 6
) (
   // clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // axi4-lite
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output      logic          awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output      logic          wready,
   output      logic [1:0]    bresp,
   output      logic          bvalid,
   input  wire logic          bready,
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output      logic          arready,
   output      logic [31:0]   rdata,
   output      logic [1:0]    rresp,
   output      logic          rvalid,
   input  wire logic          rready,
   // register file side
   output      logic          wr_stb,
   output      logic [3:0]    wr_idx,
   output      logic [7:0]    wr_data,
   output      logic          rd_stb,
   output      logic [3:0]    rd_idx,
   input  wire logic [7:0]    rd_data,
   input  wire logic          wr_hit,
   input  wire logic          rd_hit
);
   typedef struct packed {
      logic          aw_got;
      logic          w_got;
      logic [3:0]    aw_idx;
      logic [7:0]    w_dat;
      logic          w_lane0;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          wr_stb;
      logic          rd_stb;
      logic [3:0]    rd_idx;
      logic          awrdy;
      logic          wrdy;
   } aim_axi_st_t;

   aim_axi_st_t st_r;
   aim_axi_st_t st_nxt;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.wr_stb = 1'b0;
      st_nxt.rd_stb = 1'b0;
      if (awvalid && awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_idx = awaddr[5:2];
      end
      if (wvalid && wready) begin
         st_nxt.w_got   = 1'b1;
         st_nxt.w_dat   = wdata[7:0];
         st_nxt.w_lane0 = wstrb[0];
      end
      // both halves held: issue write strobe and answer together in the same cycle
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.wr_stb = st_r.w_lane0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = wr_hit ? aim_pkg::RESP_OKAY : aim_pkg::RESP_SLVERR;
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      st_nxt.arready = !st_r.arready && !st_r.rvalid && !st_r.rd_stb && arvalid;
      if (arvalid && st_r.arready) begin
         st_nxt.rd_stb = 1'b1;
         st_nxt.rd_idx = araddr[5:2];
      end
      // data sampled with the clearing strobe so the read sees pre-clear bits
      if (st_r.rd_stb) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = {24'h000000, rd_data};
         st_nxt.rresp  = rd_hit ? aim_pkg::RESP_OKAY : aim_pkg::RESP_SLVERR;
      end
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      // ready flags registered so the bus outputs come straight from flops
      st_nxt.awrdy = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.wrdy  = !st_nxt.w_got && !st_nxt.bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign awready = st_r.awrdy;
   assign wready  = st_r.wrdy;
   assign bvalid  = st_r.bvalid;
   assign bresp   = st_r.bresp;
   assign arready = st_r.arready;
   assign rvalid  = st_r.rvalid;
   assign rdata   = st_r.rdata;
   assign rresp   = st_r.rresp;
   assign wr_stb  = st_r.wr_stb;
   assign wr_idx  = st_r.aw_idx;
   assign wr_data = st_r.w_dat;
   assign rd_stb  = st_r.rd_stb;
   assign rd_idx  = st_r.rd_idx;
endmodule

// [src/aim_irq_ctrl.sv]
/*
 * interrupt gating top for the audio transceiver: two enable masks, two pairs
 * of trigger-mode registers, two sticky status registers and the irq pin.
 * assumes event conditions are synchronous levels on aclk.
 */
//
// Summary of operation
// RL1: group1 enable bit 1 passes its event to irq and status; 0 blocks it.
// RL2: group1 bits 7..0: time slip, output slip, converter error, overranges, transfers, receiver.
// RL3: group2 enable bits 5..0 gate six sources; bits 7 and 6 read zero.
// RL4: both enable registers reset to zero, masking every source.
// RL5: group1 msb and lsb trigger registers form a 2-bit code per source.
// RL6: group2 msb and lsb trigger registers form codes for bits 5..0.
// RL7: code 00 arrival, 01 removal, 10 level; 11 reserved, never programmed.
// RL8: all four trigger registers reset to zero, selecting arrival triggering.
// RL9: status bit is one after an event since last read; masked reads zero.
// RL10: reading status clears it, except level sources whose condition persists.
// RL11: irq is high while any unmasked status bit of either group is set.
`timescale 1ns/1ps
module aim_irq_ctrl (
   // clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // event conditions
   input  wire aim_pkg::aim_g1_src_t g1_src,
   input  wire aim_pkg::aim_g2_src_t g2_src,
   // axi4-lite write
   input  wire logic [5:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output      logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output      logic                 s_axi_wready,
   output      logic [1:0]           s_axi_bresp,
   output      logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read
   input  wire logic [5:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output      logic                 s_axi_arready,
   output      logic [31:0]          s_axi_rdata,
   output      logic [1:0]           s_axi_rresp,
   output      logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // interrupt
   output      logic                 irq
);
   typedef struct packed {
      aim_pkg::aim_grp_cfg_t g1;
      aim_pkg::aim_grp_cfg_t g2;
      logic                  irq;
   } aim_top_st_t;

   aim_top_st_t st_r;
   aim_top_st_t st_nxt;

   logic       wr_stb;
   logic [3:0] wr_idx;
   logic [7:0] wr_data;
   logic       rd_stb;
   logic [3:0] rd_idx;
   logic [7:0] rd_data;
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] g1_status;
   logic [5:0] g2_status;
   logic       g1_clr;
   logic       g2_clr;

   aim_axil_slave #(
      .AW (aim_pkg::ADDR_W)
   ) u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_stb  (wr_stb),
      .wr_idx  (wr_idx),
      .wr_data (wr_data),
      .rd_stb  (rd_stb),
      .rd_idx  (rd_idx),
      .rd_data (rd_data),
      .wr_hit  (wr_hit),
      .rd_hit  (rd_hit)
   );

   // the status registers are read-only; writes to them are refused
   always_comb begin
      wr_hit = 1'b0;
      unique case (wr_idx)
         aim_pkg::IDX_G1_ENABLE, aim_pkg::IDX_G1_TRIG_MSB, aim_pkg::IDX_G1_TRIG_LSB,
         aim_pkg::IDX_G2_ENABLE, aim_pkg::IDX_G2_TRIG_MSB, aim_pkg::IDX_G2_TRIG_LSB: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 8'h00;
      unique case (rd_idx)
         aim_pkg::IDX_G1_STATUS:   rd_data = g1_status;                       // [RL9]
         aim_pkg::IDX_G2_STATUS:   rd_data = {2'h0, g2_status};               // [RL3]
         aim_pkg::IDX_G1_ENABLE:   rd_data = st_r.g1.enable;
         aim_pkg::IDX_G1_TRIG_MSB: rd_data = st_r.g1.trig_msb;
         aim_pkg::IDX_G1_TRIG_LSB: rd_data = st_r.g1.trig_lsb;
         aim_pkg::IDX_G2_ENABLE:   rd_data = st_r.g2.enable;
         aim_pkg::IDX_G2_TRIG_MSB: rd_data = st_r.g2.trig_msb;
         aim_pkg::IDX_G2_TRIG_LSB: rd_data = st_r.g2.trig_lsb;
         default:                  rd_hit  = 1'b0;
      endcase
   end

   // the read strobe both samples and clears, so no event is lost between them
   assign g1_clr = rd_stb && (rd_idx == aim_pkg::IDX_G1_STATUS); // [RL10]
   assign g2_clr = rd_stb && (rd_idx == aim_pkg::IDX_G2_STATUS); // [RL10]

   aim_trigger #(
      .N (aim_pkg::G1_SRC)
   ) u_g1 (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .cond     (g1_src),           // [RL2]
      .enable   (st_r.g1.enable),
      .trig_msb (st_r.g1.trig_msb),
      .trig_lsb (st_r.g1.trig_lsb),
      .rd_clear (g1_clr),
      .status   (g1_status)
   );

   aim_trigger #(
      .N (aim_pkg::G2_SRC)
   ) u_g2 (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .cond     (g2_src),
      .enable   (st_r.g2.enable[5:0]),
      .trig_msb (st_r.g2.trig_msb[5:0]),
      .trig_lsb (st_r.g2.trig_lsb[5:0]),
      .rd_clear (g2_clr),
      .status   (g2_status)
   );

   always_comb begin
      st_nxt = st_r;
      if (wr_stb) begin
         unique case (wr_idx)
            aim_pkg::IDX_G1_ENABLE:   st_nxt.g1.enable   = wr_data;                      // [RL1]
            aim_pkg::IDX_G1_TRIG_MSB: st_nxt.g1.trig_msb = wr_data;                      // [RL5]
            aim_pkg::IDX_G1_TRIG_LSB: st_nxt.g1.trig_lsb = wr_data;                      // [RL5]
            aim_pkg::IDX_G2_ENABLE:   st_nxt.g2.enable   = wr_data & aim_pkg::G2_VALID;  // [RL3]
            aim_pkg::IDX_G2_TRIG_MSB: st_nxt.g2.trig_msb = wr_data & aim_pkg::G2_VALID;  // [RL6]
            aim_pkg::IDX_G2_TRIG_LSB: st_nxt.g2.trig_lsb = wr_data & aim_pkg::G2_VALID;  // [RL6]
            default: ;
         endcase
      end
      // status is already masked; the extra gate covers a mask cleared this cycle
      st_nxt.irq = |(g1_status & st_nxt.g1.enable) | |(g2_status & st_nxt.g2.enable[5:0]); // [RL11]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r.g1  <= '{aim_pkg::RST_REG8, aim_pkg::RST_REG8, aim_pkg::RST_REG8}; // [RL4] [RL8]
         st_r.g2  <= '{aim_pkg::RST_REG8, aim_pkg::RST_REG8, aim_pkg::RST_REG8}; // [RL4] [RL8]
         st_r.irq <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign irq = st_r.irq;

   AST_IRQ_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
      (|g1_status && $stable(st_r.g1.enable) && !wr_stb) |=> irq) else $error("irq missing"); // [RL11]
   AST_IRQ_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      (g1_status == 8'h00 && g2_status == 6'h00) |=> !irq) else $error("irq stuck"); // [RL11]
   AST_G2_HI_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.g2.enable[7:6] == 2'h0) else $error("group2 upper bits set"); // [RL3]
   AST_MASK_GATES: assert property (@(posedge aclk) disable iff (!aresetn)
      (g1_status & ~st_r.g1.enable) == 8'h00) else $error("masked group1 status set"); // [RL1]
   AST_RISE_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_r.g1.enable[7] && !st_r.g1.trig_msb[7] && !st_r.g1.trig_lsb[7] && !g1_src[7] ##1
       g1_src[7] && $stable(st_r.g1) && !wr_stb) |=> g1_status[7]) else $error("rising event lost"); // [RL7]
   AST_FALL_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_r.g1.enable[0] && !st_r.g1.trig_msb[0] && st_r.g1.trig_lsb[0] && g1_src[0] ##1
       !g1_src[0] && $stable(st_r.g1) && !wr_stb) |=> g1_status[0]) else $error("falling event lost"); // [RL7]
   AST_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      (g1_clr && st_r.g1.trig_msb == 8'h00 && st_r.g1.trig_lsb == 8'h00 && g1_src == $past(g1_src))
      |=> g1_status == 8'h00) else $error("read did not clear"); // [RL10]
   AST_RESET_ZERO: assert property (@(posedge aclk)
      $rose(aresetn) |-> (st_r.g1 == '0 && st_r.g2 == '0 && !irq)) else $error("reset value wrong"); // [RL4]
   AST_TRIG_RESET: assert property (@(posedge aclk)
      $rose(aresetn) |-> (st_r.g1.trig_msb == 8'h00 && st_r.g2.trig_lsb == 8'h00))
      else $error("trigger reset wrong"); // [RL8]
   AST_G2_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_stb && wr_idx == aim_pkg::IDX_G2_TRIG_MSB) |=> st_r.g2.trig_msb == ($past(wr_data) & 8'h3f))
      else $error("group2 trigger write wrong"); // [RL6]
   AST_G1_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_stb && wr_idx == aim_pkg::IDX_G1_ENABLE) |=> st_r.g1.enable == $past(wr_data))
      else $error("group1 enable write wrong"); // [RL1]
endmodule

// [verif/aim_host.sv]
/*
 * host model: an axi4-lite master that drives the register bus; it has no irq input.
 * assumes a testbench module named testbench with an on_timeout task.
 */
`timescale 1ns/1ps
module aim_host (
   // clock
   input  wire logic        aclk,
   // write channels
   output      logic [5:0]  awaddr,
   output      logic        awvalid,
   input  wire logic        awready,
   output      logic [31:0] wdata,
   output      logic [3:0]  wstrb,
   output      logic        wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output      logic        bready,
   // read channels
   output      logic [5:0]  araddr,
   output      logic        arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output      logic        rready
);
   // response ready stays high: always able to take an answer
   initial begin
      awaddr  = 6'h00;
      awvalid = 1'b0;
      wdata   = 32'h0;
      wstrb   = 4'hf;
      wvalid  = 1'b0;
      bready  = 1'b1;
      araddr  = 6'h00;
      arvalid = 1'b0;
      rready  = 1'b1;
   end

   // called right after a rising edge; callers never program trigger code 11
   task automatic write(input logic [3:0] idx, input logic [7:0] data, output logic [1:0] resp);
      int n;
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h0, data};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            return;
         end
      end
      testbench.on_timeout();
   endtask

   task automatic read(input logic [3:0] idx, output logic [31:0] data, output logic [1:0] resp);
      int n;
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            data = rdata;
            resp = rresp;
            return;
         end
      end
      testbench.on_timeout();
   endtask
endmodule

// [verif/testbench.sv]
/*
 * self-checking bench for the interrupt gating block.
 * assumes the host model drives the register bus; events are driven here.
 */
`timescale 1ns/1ps
module testbench;
   logic                 aclk;
   logic                 aresetn;
   aim_pkg::aim_g1_src_t g1_src;
   aim_pkg::aim_g2_src_t g2_src;
   logic [5:0]           awaddr, araddr;
   logic [31:0]          wdata, rdata;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready;
   logic                 arvalid, arready, rvalid, rready, irq;
   int                   fails;
   int                   checks;

   localparam logic [1:0] OK  = aim_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = aim_pkg::RESP_SLVERR;

   aim_irq_ctrl aim_irq_ctrl_inst (
      .aclk(aclk), .aresetn(aresetn), .g1_src(g1_src), .g2_src(g2_src),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq)
   );

   aim_host aim_host_inst (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic complete_run;
      if (fails == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic on_timeout;
      fails++;
      $display("ERROR %0t bus answer never came", $time);
      complete_run();
   endtask

   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t response %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_irq(input logic exp);
      checks++;
      if (irq !== exp) begin
         fails++;
         $display("ERROR %0t irq %b expected %b", $time, irq, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] data, input logic [1:0] exp);
      logic [1:0] r;
      aim_host_inst.write(idx, data, r);
      cmp_resp(r, exp);
   endtask

   task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input logic [1:0] xr);
      logic [31:0] d;
      logic [1:0]  r;
      aim_host_inst.read(idx, d, r);
      cmp_data(d, {24'h0, exp});
      cmp_resp(r, xr);
   endtask

   task automatic t_reset_values;
      for (int i = 7; i <= 14; i++) rd(4'(i), aim_pkg::RST_REG8, OK);
      cmp_irq(1'b0);
   endtask

   task automatic t_reg_access;
      wr(4'h9, 8'ha5, OK);
      rd(4'h9, 8'ha5, OK);
      wr(4'ha, 8'h5a, OK);
      wr(4'hb, 8'ha5, OK);
      rd(4'ha, 8'h5a, OK);
      rd(4'hb, 8'ha5, OK);
      for (int i = 12; i <= 13; i++) begin
         wr(4'(i), 8'hff, OK);
         rd(4'(i), aim_pkg::G2_VALID, OK);
      end
      // clear the msb bits first so no source ever holds the reserved code
      wr(4'hd, 8'h00, OK);
      wr(4'he, 8'hc1, OK);
      rd(4'he, 8'h01, OK);
      // unmapped index and read-only status are refused
      wr(4'hf, 8'hff, ERR);
      rd(4'hf, 8'h00, ERR);
      wr(4'h7, 8'hff, ERR);
      for (int i = 9; i <= 14; i++) wr(4'(i), 8'h00, OK);
      rd(4'h7, 8'h00, OK);
   endtask

   task automatic t_mask;
      g1_src <= 8'hff;
      g2_src <= 6'h3f;
      cyc(3);
      g1_src <= 8'h00;
      g2_src <= 6'h00;
      cyc(4);
      cmp_irq(1'b0);
      rd(4'h7, 8'h00, OK);
      rd(4'h8, 8'h00, OK);
      wr(4'h9, 8'h01, OK);
      g1_src <= 8'h01;
      cyc(4);
      cmp_irq(1'b1);
      wr(4'h9, 8'h00, OK);
      cyc(3);
      cmp_irq(1'b0);
      g1_src <= 8'h00;
      rd(4'h7, 8'h00, OK);
   endtask

   // every source in arrival mode, one at a time
   task automatic t_rise;
      wr(4'h9, 8'hff, OK);
      wr(4'hc, 8'h3f, OK);
      for (int g = 0; g < 2; g++) begin
         for (int i = 0; i < (g ? aim_pkg::G2_SRC : aim_pkg::G1_SRC); i++) begin
            if (g) g2_src <= 6'(1 << i);
            else g1_src <= 8'(1 << i);
            cyc(4);
            cmp_irq(1'b1);
            g1_src <= 8'h00;
            g2_src <= 6'h00;
            rd(g ? 4'h8 : 4'h7, 8'(1 << i), OK);
            rd(g ? 4'h8 : 4'h7, 8'h00, OK);
            cyc(3);
            cmp_irq(1'b0);
         end
      end
   endtask

   task automatic t_fall;
      wr(4'hb, 8'h01, OK);
      g1_src <= 8'h01;
      cyc(4);
      rd(4'h7, 8'h00, OK);
      g1_src <= 8'h00;
      cyc(4);
      cmp_irq(1'b1);
      rd(4'h7, 8'h01, OK);
      rd(4'h7, 8'h00, OK);
   endtask

   task automatic t_level;
      wr(4'hd, 8'h20, OK);
      g2_src <= 6'h20;
      cyc(4);
      rd(4'h8, 8'h20, OK);
      rd(4'h8, 8'h20, OK);
      cmp_irq(1'b1);
      g2_src <= 6'h00;
      cyc(4);
      rd(4'h8, 8'h20, OK);
      rd(4'h8, 8'h00, OK);
      cyc(3);
      cmp_irq(1'b0);
   endtask

   // reset in mid-run with registers programmed and a level event pending
   task automatic t_reset_again;
      wr(4'h9, 8'h5a, OK);
      wr(4'he, 8'h1f, OK);
      g2_src <= 6'h20;
      cyc(4);
      cmp_irq(1'b1);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      cyc(1);
      rd(4'h9, aim_pkg::RST_REG8, OK);
      rd(4'hc, aim_pkg::RST_REG8, OK);
      rd(4'hd, aim_pkg::RST_REG8, OK);
      rd(4'he, aim_pkg::RST_REG8, OK);
      rd(4'h8, 8'h00, OK);
      cmp_irq(1'b0);
      g2_src <= 6'h00;
   endtask

   initial begin
      fails   = 0;
      checks  = 0;
      aresetn = 1'b0;
      g1_src  = 8'h00;
      g2_src  = 6'h00;
      cyc(16);
      aresetn <= 1'b1;
      cyc(1);
      t_reset_values();
      t_reg_access();
      t_mask();
      t_rise();
      t_fall();
      t_level();
      t_reset_again();
      complete_run();
   end
endmodule
